// ===== hdl/fepc_pkg.sv
// shared constants and types for the flash erase/program controller
package fepc_pkg;

    // special-function register addresses
    localparam logic [7:0] ADDR_TIMING = 8'hAB;
    localparam logic [7:0] ADDR_ADDR_LOW = 8'hAC;
    localparam logic [7:0] ADDR_ADDR_HIGH = 8'hAD;
    localparam logic [7:0] ADDR_CONTROL = 8'hAE;
    localparam logic [7:0] ADDR_WDATA = 8'hAF;

    // control/status field positions
    localparam int CTL_ERASE_BIT = 0;
    localparam int CTL_WRITE_BIT = 1;
    localparam int CTL_CONTINUOUS_READ_EN_BIT = 4;
    localparam int CTL_WORD_PROG_BUSY_BIT = 6;
    localparam int CTL_BUSY_BIT = 7;

    // reset values
    localparam logic [7:0] RST_ADDR_LOW = 8'h00;
    localparam logic [7:0] RST_ADDR_HIGH = 8'h00;
    localparam logic [7:0] RST_WDATA = 8'h00;
    localparam logic [5:0] RST_TIMING = 6'h11;

    // flash trigger code the dma channel selects for this block
    localparam logic [4:0] DMA_DMA_TRIGGER_SELECT_FLASH = 5'h12;

    // one timing-generator tick lasts timing-field clocks:
    // 21000 / 16e9 seconds, i.e. 1312500000 fs
    localparam longint TICK_FS = 64'd1312500000;
    localparam longint ERASE_TIME_US = 64'd20000;
    localparam longint PROG_TIME_US = 64'd20;
    localparam longint TIMEOUT_TIME_US = 64'd40;
    localparam longint US_FS = 64'd1000000000;
    // least times round up, the longest wait rounds down
    localparam int ERASE_TICKS_DEF =
        int'((ERASE_TIME_US * US_FS + TICK_FS - 1) / TICK_FS);
    localparam int PROG_TICKS =
        int'((PROG_TIME_US * US_FS + TICK_FS - 1) / TICK_FS);
    localparam int TIMEOUT_TICKS =
        int'((TIMEOUT_TIME_US * US_FS) / TICK_FS);
    localparam int TCNT_W = 14;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ERASE,
        ST_WAIT_DATA,
        ST_PROG
    } fepc_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } fepc_sfr_req_t;

    typedef struct packed {
        logic erase;
        logic [4:0] page;
        logic prog;
        logic [13:0] word_addr;
        logic [15:0] data;
        logic cont_read;
    } fepc_flash_cmd_t;

endpackage : fepc_pkg

// ===== hdl/fepc_timing_gen.sv
// timing generator: one tick every timing-field clocks while running
`timescale 1ns/1ps
module fepc_timing_gen (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic run_in,
    input wire logic [5:0] timing_in,
    output logic tick_out
);
    import fepc_pkg::*;

    typedef struct packed {
        logic [5:0] cnt;
        logic tick;
    } fepc_tg_t;

    fepc_tg_t st_reg;
    fepc_tg_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (!run_in) begin
            st_next.cnt = 6'h00;
        // a zero field is taken as one so the generator never stalls
        end else if (st_reg.cnt + 6'h01 >= timing_in) begin
            st_next.cnt = 6'h00;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt + 6'h01;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick_out = st_reg.tick;

endmodule : fepc_timing_gen

// ===== hdl/fepc_ctrl.sv
// flash erase/program controller: sfr registers, sequencer, dma requests
//
// Functional notes
// - after page erase the flash array holds all ones in that page
// - erase command erases the page in address-high bits 5:1
// - erase and program set together: erase first, then program
// - control bit 7 reads busy during any write or erase
// - page erase lasts about 20 ms
// - instruction fetch from flash stalls until the operation ends
// - program command raises the first dma request
// - further dma request whenever write-data can take a byte
// - timing generator uses 6-bit timing field set by software
// - timing field resets to 0x11
// - bit 6 set after two bytes, held during word programming
// - control bit 4 is continuous read enable, reset 0
// - writing 1 to bit 1 starts programming, reads 0
// - writing 1 to bit 0 starts page erase, reads 0
// - command bits are 0 after return from deep low power
// - each byte pair written starts one word programming
// - address-high bits 5:0 are read/write, reset zero
// - first byte is low byte, second is high byte of the word
// - 512 words per page, word chosen by high bit 0 and low byte
// - word not supplied within 40 us abandons write, keeps address
// - address-low register is 8 bits read/write, reset zero
`timescale 1ns/1ps
module fepc_ctrl #(
    parameter int unsigned ERASE_TICKS = fepc_pkg::ERASE_TICKS_DEF
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input fepc_pkg::fepc_sfr_req_t sfr_req_in,
    input wire logic exec_from_flash_in,
    input wire logic pm_wake_in,
    output logic [7:0] sfr_rdata_out,
    output fepc_pkg::fepc_flash_cmd_t flash_cmd_out,
    output logic dma_req_out,
    output logic cpu_stall_out
);
    import fepc_pkg::*;

    typedef struct packed {
        fepc_state_t state;
        logic [7:0] addr_low;
        logic [7:0] addr_high;
        logic [5:0] timing;
        logic cont_read;
        logic [7:0] wdata;
        logic [7:0] low_byte;
        logic have_low;
        logic pend_write;
        logic [TCNT_W-1:0] tick_cnt;
        logic dma_req;
        logic [7:0] rdata;
        logic erase;
        logic [4:0] page;
        logic prog;
        logic [15:0] prog_data;
        logic stall;
    } fepc_st_t;

    fepc_st_t st_reg;
    fepc_st_t st_next;
    logic tick;
    logic busy;
    logic swbusy;
    logic wr_ctl;
    logic wr_data;
    logic [13:0] word_addr;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    assign busy = (st_reg.state != ST_IDLE);
    assign swbusy = (st_reg.state == ST_PROG);
    assign wr_ctl = sfr_req_in.wr && hit(sfr_req_in.addr, ADDR_CONTROL);
    assign wr_data = sfr_req_in.wr && hit(sfr_req_in.addr, ADDR_WDATA);
    assign word_addr = {st_reg.addr_high[5:0], st_reg.addr_low};

    fepc_timing_gen u_timing (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .run_in(busy),
        .timing_in(st_reg.timing),
        .tick_out(tick)
    );

    always_comb begin
        st_next = st_reg;
        st_next.dma_req = 1'b0;

        // read port: command and unused bits read zero; address-high bits 7:6 read back as written
        if (sfr_req_in.rd) begin
            if (hit(sfr_req_in.addr, ADDR_CONTROL)) begin
                st_next.rdata = 8'h00;
                st_next.rdata[CTL_BUSY_BIT] = busy;
                st_next.rdata[CTL_WORD_PROG_BUSY_BIT] = swbusy;
                st_next.rdata[CTL_CONTINUOUS_READ_EN_BIT] = st_reg.cont_read;
            end else if (hit(sfr_req_in.addr, ADDR_ADDR_HIGH)) begin
                st_next.rdata = st_reg.addr_high;
            end else if (hit(sfr_req_in.addr, ADDR_ADDR_LOW)) begin
                st_next.rdata = st_reg.addr_low;
            end else if (hit(sfr_req_in.addr, ADDR_WDATA)) begin
                st_next.rdata = st_reg.wdata;
            end else if (hit(sfr_req_in.addr, ADDR_TIMING)) begin
                st_next.rdata = {2'b00, st_reg.timing};
            end else begin
                st_next.rdata = 8'h00;
            end
        end

        // plain register writes; the sequencer may override the address
        if (sfr_req_in.wr) begin
            if (hit(sfr_req_in.addr, ADDR_ADDR_HIGH)) begin
                st_next.addr_high = sfr_req_in.wdata;
            end
            if (hit(sfr_req_in.addr, ADDR_ADDR_LOW)) begin
                st_next.addr_low = sfr_req_in.wdata;
            end
            if (hit(sfr_req_in.addr, ADDR_TIMING)) begin
                st_next.timing = sfr_req_in.wdata[5:0];
            end
            if (wr_ctl) begin
                st_next.cont_read =
                    sfr_req_in.wdata[CTL_CONTINUOUS_READ_EN_BIT];
            end
        end
        // a write-data write that arrives during word programming is dropped by the hardware
        if (wr_data && !swbusy) begin
            st_next.wdata = sfr_req_in.wdata;
        end

        if (tick) begin
            st_next.tick_cnt = st_reg.tick_cnt + TCNT_W'(1);
        end

        case (st_reg.state)
            ST_IDLE: begin
                st_next.tick_cnt = '0;
                st_next.have_low = 1'b0;
                if (wr_ctl && sfr_req_in.wdata[CTL_ERASE_BIT]) begin
                    // page latched now; later address writes do not move it
                    st_next.state = ST_ERASE;
                    st_next.page = st_reg.addr_high[5:1];
                    st_next.erase = 1'b1;
                    st_next.pend_write =
                        sfr_req_in.wdata[CTL_WRITE_BIT];
                end else if (wr_ctl && sfr_req_in.wdata[CTL_WRITE_BIT]) begin
                    st_next.state = ST_WAIT_DATA;
                    st_next.dma_req = 1'b1;
                end
            end
            ST_ERASE: begin
                if (tick && st_reg.tick_cnt ==
                        TCNT_W'(ERASE_TICKS - 1)) begin
                    st_next.erase = 1'b0;
                    st_next.tick_cnt = '0;
                    st_next.pend_write = 1'b0;
                    if (st_reg.pend_write) begin
                        st_next.state = ST_WAIT_DATA;
                        st_next.dma_req = 1'b1;
                    end else begin
                        st_next.state = ST_IDLE;
                    end
                end
            end
            ST_WAIT_DATA: begin
                if (wr_data && !st_reg.have_low) begin
                    st_next.low_byte = sfr_req_in.wdata;
                    st_next.have_low = 1'b1;
                    st_next.dma_req = 1'b1;
                end else if (wr_data) begin
                    st_next.prog_data =
                        {sfr_req_in.wdata, st_reg.low_byte};
                    st_next.have_low = 1'b0;
                    st_next.prog = 1'b1;
                    st_next.state = ST_PROG;
                    st_next.tick_cnt = '0;
                end else if (tick && st_reg.tick_cnt ==
                        TCNT_W'(TIMEOUT_TICKS - 1)) begin
                    // abandon: address registers still name the failed word
                    st_next.state = ST_IDLE;
                    st_next.have_low = 1'b0;
                end
            end
            ST_PROG: begin
                if (tick && st_reg.tick_cnt ==
                        TCNT_W'(PROG_TICKS - 1)) begin
                    st_next.prog = 1'b0;
                    {st_next.addr_high[5:0], st_next.addr_low} =
                        word_addr + 14'h0001;
                    st_next.state = ST_WAIT_DATA;
                    st_next.tick_cnt = '0;
                    st_next.dma_req = 1'b1;
                end
            end
            default: begin
                st_next.state = ST_IDLE;
            end
        endcase

        // leaving deep low power drops any queued command
        if (pm_wake_in) begin
            st_next.pend_write = 1'b0;
        end

        // fetch from flash waits for the controller to go idle
        st_next.stall = exec_from_flash_in &&
            (st_next.state != ST_IDLE);
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_reg <= '0;
            st_reg.state <= ST_IDLE;
            st_reg.addr_low <= RST_ADDR_LOW;
            st_reg.addr_high <= RST_ADDR_HIGH;
            st_reg.wdata <= RST_WDATA;
            st_reg.timing <= RST_TIMING;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sfr_rdata_out = st_reg.rdata;
    assign dma_req_out = st_reg.dma_req;
    assign cpu_stall_out = st_reg.stall;
    assign flash_cmd_out = '{erase: st_reg.erase, page: st_reg.page,
        prog: st_reg.prog, word_addr: word_addr,
        data: st_reg.prog_data, cont_read: st_reg.cont_read};

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    AST_BUSY_READ: assert property (
        sfr_req_in.rd && hit(sfr_req_in.addr, ADDR_CONTROL)
        |=> sfr_rdata_out[CTL_BUSY_BIT] == $past(busy))
        else $error("busy bit does not follow operation state");

    AST_ZERO_BITS: assert property (
        sfr_req_in.rd && hit(sfr_req_in.addr, ADDR_CONTROL)
        |=> sfr_rdata_out[5] == 1'b0 && sfr_rdata_out[3:0] == 4'h0)
        else $error("command or unused control bits read nonzero");

    AST_ERASE_FIRST: assert property (
        st_reg.state == ST_IDLE && wr_ctl && sfr_req_in.wdata[1:0] == 2'h3
        && !pm_wake_in
        |=> st_reg.state == ST_ERASE && st_reg.pend_write
            && !flash_cmd_out.prog)
        else $error("erase did not precede program");

    AST_ERASE_PAGE: assert property (
        $rose(flash_cmd_out.erase)
        |-> flash_cmd_out.page == $past(st_reg.addr_high[5:1]))
        else $error("erased page differs from address high bits");

    AST_FIRST_DMA: assert property (
        st_reg.state == ST_IDLE && wr_ctl
        && sfr_req_in.wdata[1:0] == 2'h2
        |=> dma_req_out ##1 (!dma_req_out || $past(wr_data)))
        else $error("program command did not raise one dma request");

    AST_WORD_PAIR: assert property (
        st_reg.state == ST_WAIT_DATA && wr_data && st_reg.have_low
        |=> swbusy && flash_cmd_out.prog
            && flash_cmd_out.data == {$past(sfr_req_in.wdata),
                $past(st_reg.low_byte)})
        else $error("word not assembled low byte first");

    AST_ADDR_STEP: assert property (
        $fell(flash_cmd_out.prog) && st_reg.state == ST_WAIT_DATA
        |-> word_addr == $past(word_addr) + 14'h0001)
        else $error("word address did not advance by one");

    AST_STALL: assert property (
        cpu_stall_out == (busy && $past(exec_from_flash_in)))
        else $error("fetch stall does not follow flash operation");

    AST_WAKE_CLEAR: assert property (
        pm_wake_in |=> !st_reg.pend_write)
        else $error("queued command survived low power return");

    AST_DMA_AFTER_WORD: assert property (
        $fell(swbusy) && st_reg.state == ST_WAIT_DATA |-> dma_req_out)
        else $error("no dma request after word programmed");

    AST_PROG_LEVEL: assert property (
        flash_cmd_out.prog == swbusy)
        else $error("word programming level and busy bit disagree");

    AST_ERASE_EXCL: assert property (
        flash_cmd_out.erase |-> !flash_cmd_out.prog)
        else $error("erase and program active together");

    AST_BUSY_START: assert property (
        st_reg.state == ST_IDLE && wr_ctl
        && sfr_req_in.wdata[1:0] != 2'h0
        |=> busy)
        else $error("command bit did not start an operation");

    AST_CMD_IGNORED: assert property (
        busy && wr_ctl |=> $stable(flash_cmd_out.page))
        else $error("command taken while busy moved the page");

    AST_WDATA_LOCK: assert property (
        swbusy && wr_data |=> $stable(st_reg.wdata))
        else $error("write data changed during word programming");

    AST_CONT_READ: assert property (
        wr_ctl |=> flash_cmd_out.cont_read
            == $past(sfr_req_in.wdata[CTL_CONTINUOUS_READ_EN_BIT]))
        else $error("continuous read enable not stored");

    AST_TIMING_WRITE: assert property (
        sfr_req_in.wr && hit(sfr_req_in.addr, ADDR_TIMING)
        |=> st_reg.timing == $past(sfr_req_in.wdata[5:0]))
        else $error("timing field not stored");

    AST_ADDR_WRITE: assert property (
        sfr_req_in.wr && hit(sfr_req_in.addr, ADDR_ADDR_HIGH)
        && st_reg.state != ST_PROG
        |=> st_reg.addr_high == $past(sfr_req_in.wdata))
        else $error("address high not stored");

    AST_FIRST_BYTE_DMA: assert property (
        st_reg.state == ST_WAIT_DATA && wr_data && !st_reg.have_low
        |=> dma_req_out)
        else $error("no dma request after first byte");

    AST_ERASE_LEN: assert property (
        $fell(flash_cmd_out.erase)
        |-> $past(st_reg.tick_cnt) == TCNT_W'(ERASE_TICKS - 1))
        else $error("page erase ended at the wrong tick count");

    AST_PROG_LEN: assert property (
        $fell(flash_cmd_out.prog)
        |-> $past(st_reg.tick_cnt) == TCNT_W'(PROG_TICKS - 1))
        else $error("word programming ended at the wrong tick count");

    AST_TIMEOUT: assert property (
        st_reg.state == ST_WAIT_DATA && !sfr_req_in.wr
        && tick && st_reg.tick_cnt == TCNT_W'(TIMEOUT_TICKS - 1)
        |=> !busy && $stable(word_addr))
        else $error("timed out write did not stop at the failing word");

endmodule : fepc_ctrl

// ===== sim/fepc_flash_model.sv
// behavioural flash array and dma channel counter facing the controller
`timescale 1ns/1ps
module fepc_flash_model (
    input wire logic ref_clk_in,
    input fepc_pkg::fepc_flash_cmd_t flash_cmd_in,
    input wire logic dma_req_in,
    output int dma_cnt_out,
    output int erase_cycles_out
);
    import fepc_pkg::*;
    logic [15:0] mem [logic [13:0]];
    logic erase_prev = 1'b0;
    logic prog_prev = 1'b0;
    // the channel is armed on the flash trigger code
    logic [4:0] dma_trigger_select = DMA_DMA_TRIGGER_SELECT_FLASH;
    initial dma_cnt_out = 0;
    initial erase_cycles_out = 0;
    // cells never touched read zero, so a missed erase shows up
    function automatic logic [15:0] peek(input logic [13:0] a);
        return mem.exists(a) ? mem[a] : 16'h0000;
    endfunction : peek
    always @(posedge ref_clk_in) begin
        if (dma_req_in === 1'b1 && dma_trigger_select == DMA_DMA_TRIGGER_SELECT_FLASH)
            dma_cnt_out++;
        if (flash_cmd_in.erase === 1'b1) begin
            erase_cycles_out = erase_prev ? erase_cycles_out + 1 : 1;
        end
        if (flash_cmd_in.erase === 1'b1 && !erase_prev) begin
            for (int i = 0; i < 512; i++) begin
                mem[{flash_cmd_in.page, 9'(i)}] = 16'hFFFF;
            end
        end
        // programming only clears bits
        if (flash_cmd_in.prog === 1'b1 && !prog_prev) begin
            mem[flash_cmd_in.word_addr] =
                peek(flash_cmd_in.word_addr) & flash_cmd_in.data;
        end
        erase_prev = flash_cmd_in.erase;
        prog_prev = flash_cmd_in.prog;
    end
endmodule : fepc_flash_model

// ===== sim/tb.sv
// self-checking bench for the flash erase/program controller
`timescale 1ns/1ps
module tb;
    import fepc_pkg::*;
    localparam int ERASE_N = 20;
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    fepc_sfr_req_t sfr_req = '0;
    logic exec_ff = 1'b0;
    logic pm_wake = 1'b0;
    logic [7:0] rdata;
    fepc_flash_cmd_t cmd;
    logic dma_req;
    logic stall;
    int dma_cnt, erase_len, n, d0;
    int failures = 0;
    int checked = 0;
    int seed = 32'h1adf;
    logic [7:0] v, lo, hi, ah, al;
    logic [13:0] wa;
    logic [15:0] dw [2];
    logic [7:0] ra [6] = '{8'hAB, 8'hAC, 8'hAD, 8'hAE, 8'hAF, 8'h55};
    logic [7:0] rv [6] = '{8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    fepc_ctrl #(.ERASE_TICKS(ERASE_N)) u_fepc_ctrl (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .sfr_req_in(sfr_req), .exec_from_flash_in(exec_ff),
        .pm_wake_in(pm_wake), .sfr_rdata_out(rdata),
        .flash_cmd_out(cmd), .dma_req_out(dma_req), .cpu_stall_out(stall)
    );
    fepc_flash_model u_fepc_flash_model (
        .ref_clk_in(ref_clk_in), .flash_cmd_in(cmd), .dma_req_in(dma_req),
        .dma_cnt_out(dma_cnt), .erase_cycles_out(erase_len)
    );

    initial begin
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                       input string m);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %s %h not %h", $time, m, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_in);
        sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge ref_clk_in);
        sfr_req = '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk_in);
        sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge ref_clk_in);
        sfr_req = '0;
        d = rdata;
    endtask : rd
    task automatic wait_lvl(input bit pick, input logic lvl, output int c);
        c = 0;
        while ((pick ? cmd.prog : cmd.erase) !== lvl && c < 300) begin
            @(negedge ref_clk_in);
            c++;
        end
        if (c >= 300) chk(16'h0, 16'h1, "wait limit");
    endtask : wait_lvl
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    initial begin
        #(25 * 8000); // software watchdog span outlasts any erase
        failures++;
        $display("wrong value at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        repeat (10) @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        chk({dma_req, stall, cmd.erase, cmd.prog}, 4'h0,
            "reset outs");
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], v);
            chk(v, rv[i], "reset value");
        end
        $display("test reset finished");
        for (int i = 0; i < 4; i++) begin
            al = 8'($random(seed));
            ah = 8'($random(seed));
            wr(ADDR_ADDR_LOW, al);
            wr(ADDR_ADDR_HIGH, ah);
            rd(ADDR_ADDR_LOW, v);
            chk(v, al, "address low");
            rd(ADDR_ADDR_HIGH, v);
            chk(v, ah, "address high");
        end
        wr(ADDR_CONTROL, 8'h3C);
        rd(ADDR_CONTROL, v);
        chk(v, 8'h10, "control bits");
        chk(cmd.cont_read, 1'b1, "continuous read");
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_CONTROL, v);
        chk(v, 8'h00, "control clear");
        wr(ADDR_TIMING, 8'hFF);
        rd(ADDR_TIMING, v);
        chk(v, 8'h3F, "timing field");
        wr(8'h55, 8'hA5);
        rd(8'h55, v);
        chk(v, 8'h00, "unmapped");
        $display("test registers finished");
        exec_ff = 1'b1;
        for (int t = 1; t <= 2; t++) begin
            ah = {2'b00, 5'($random(seed)), 1'b0};
            wr(ADDR_TIMING, 8'(t));
            wr(ADDR_ADDR_HIGH, ah);
            wr(ADDR_CONTROL, 8'h01);
            @(negedge ref_clk_in); // quiet slot after the erase command
            wait_lvl(0, 1'b1, n);
            chk(cmd.page, ah[5:1], "erase page");
            rd(ADDR_CONTROL, v);
            chk(v, 8'h80, "busy in erase");
            chk(stall, 1'b1, "fetch stall");
            wait_lvl(0, 1'b0, n);
            n = erase_len;
            chk(n >= ERASE_N * t - t && n <= ERASE_N * t + t + 1, 1'b1,
                "erase length");
            repeat (2) @(negedge ref_clk_in);
            chk(stall, 1'b0, "stall end");
            rd(ADDR_CONTROL, v);
            chk(v, 8'h00, "idle after erase");
            wa = {ah[5:1], 9'($random(seed))};
            chk(u_fepc_flash_model.peek(wa), 16'hFFFF, "erased");
        end
        exec_ff = 1'b0;
        $display("test erase finished");
        wr(ADDR_TIMING, 8'h01);
        al = 8'($random(seed));
        wa = {ah[5:0], al};
        wr(ADDR_ADDR_LOW, al);
        d0 = dma_cnt;
        wr(ADDR_CONTROL, 8'h03);
        wait_lvl(0, 1'b1, n);
        repeat (ERASE_N / 2) @(negedge ref_clk_in);
        chk(dma_cnt, d0, "dma in erase");
        chk(cmd.prog, 1'b0, "prog in erase");
        wait_lvl(0, 1'b0, n);
        repeat (2) @(negedge ref_clk_in);
        chk(dma_cnt, d0 + 1, "first dma");
        for (int w = 0; w < 2; w++) begin
            lo = 8'($random(seed));
            hi = 8'($random(seed));
            dw[w] = {hi, lo};
            wr(ADDR_WDATA, lo);
            @(negedge ref_clk_in);
            chk(dma_cnt, d0 + 2 + 2 * w, "dma byte");
            wr(ADDR_WDATA, hi);
            wait_lvl(1, 1'b1, n);
            chk(cmd.data, {hi, lo}, "word");
            chk(cmd.word_addr, wa + 14'(w), "word address");
            rd(ADDR_CONTROL, v);
            chk(v, 8'hC0, "word busy");
            wait_lvl(1, 1'b0, n); // no data until bit 6 falls
            @(negedge ref_clk_in);
            chk(dma_cnt, d0 + 3 + 2 * w, "dma word");
            chk(cmd.word_addr, wa + 14'(w + 1), "advance");
        end
        for (int w = 0; w < 2; w++) begin
            chk(u_fepc_flash_model.peek(wa + 14'(w)), dw[w], "stored");
        end
        repeat (40) @(negedge ref_clk_in);
        rd(ADDR_CONTROL, v);
        chk(v, 8'h00, "timeout idle");
        chk(cmd.word_addr, wa + 14'd2, "failing address");
        chk(dma_cnt, d0 + 5, "dma count");
        $display("test program finished");
        wr(ADDR_CONTROL, 8'h03);
        wait_lvl(0, 1'b1, n);
        d0 = dma_cnt;
        @(negedge ref_clk_in);
        pm_wake = 1'b1;
        @(negedge ref_clk_in);
        pm_wake = 1'b0;
        wait_lvl(0, 1'b0, n);
        repeat (3) @(negedge ref_clk_in);
        chk(cmd.prog, 1'b0, "queued program");
        chk(dma_cnt, d0, "wake dma");
        rd(ADDR_CONTROL, v);
        chk(v, 8'h00, "wake idle");
        $display("test wake finished");
        d0 = dma_cnt;
        wr(ADDR_CONTROL, 8'h02);
        @(negedge ref_clk_in);
        chk(dma_cnt, d0 + 1, "program alone dma");
        rd(ADDR_CONTROL, v);
        chk(v, 8'h80, "waiting for data");
        repeat (35) @(negedge ref_clk_in);
        rd(ADDR_CONTROL, v);
        chk(v, 8'h00, "program alone timeout");
        $display("test program alone finished");
        @(negedge ref_clk_in);
        sys_rst_in = 1'b1;
        repeat (2) @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        rd(ADDR_TIMING, v);
        chk(v, 8'h11, "timing after reset");
        rd(ADDR_ADDR_LOW, v);
        chk(v, 8'h00, "address after reset");
        $display("test mid reset finished");
        tally_and_finish();
    end
endmodule : tb
